/* File: verilog/tws_pkg.sv */
// two-wire slave read engine: shared constants, states and carriers
// assumes a single system clock domain; bus pins arrive unsynchronised
package tws_pkg;

  // ************************************************************
  // protocol constants
  // ************************************************************
  localparam int         BYTE_W     = 8;
  localparam logic [3:0] BYTE_BITS  = 4'h8;
  localparam logic [3:0] CTRL_CODE  = 4'hA;
  localparam logic [2:0] FIX_SEL    = 3'h0;
  localparam logic [7:0] PTR_RST    = 8'h00;
  localparam logic [7:0] EMPTY_BYTE = 8'hFF;
  localparam logic [2:0] SYNC_RST   = 3'h7;
  localparam int         FIFO_DEPTH = 8;

  // ************************************************************
  // types
  // ************************************************************
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_PTR,
    ST_DATA,
    ST_ACK,
    ST_TX,
    ST_MACK
  } tws_state_type;

  // memory read answer for the presented address
  typedef struct packed {
    logic        valid;
    logic [7:0]  data;
  } tws_mem_rsp_type;

  // open-drain data pin drive
  typedef struct packed {
    logic        o;
    logic        oe;
  } tws_pin_out_type;

  // whole state of the engine
  typedef struct packed {
    logic [2:0]    scl_s;
    logic [2:0]    sda_s;
    logic          scl_f;
    logic          sda_f;
    tws_state_type st;
    logic [3:0]    bitc;
    logic [7:0]    sh;
    logic [7:0]    ptr;
    logic [7:0]    fetch;
    logic          oe;
    logic          rw;
    logic          ptr_done;
    logic          mack;
  } tws_core_type;

endpackage : tws_pkg

/* File: verilog/tws_fifo.sv */
// tws_fifo: small first-word-fall-through buffer with flush
// assumes depth is a power of two; one clock domain
`timescale 1ns/1ps
module tws_fifo #(
  parameter int W = 8,
  parameter int D = 8
) (
  input  wire logic         mclk,
  input  wire logic         rstn,
  input  wire logic         flush,
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output logic              in_ready,
  output logic              out_valid,
  output logic [W-1:0]      out_data,
  input  wire logic         out_ready
);

  localparam int AW = $clog2(D);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       rd;
    logic [AW-1:0]       wr;
    logic [AW:0]         cnt;
  } tws_fifo_state_type;

  tws_fifo_state_type q;
  tws_fifo_state_type d;
  logic               push;
  logic               pop;

  // handshakes from the fill level
  assign in_ready  = (q.cnt != (AW+1)'(D));
  assign out_valid = (q.cnt != '0);
  assign out_data  = q.mem[q.rd];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // next state; flush empties the buffer and wins over traffic
  always_comb begin
    d = q;
    if (flush) begin
      d.rd  = '0;
      d.wr  = '0;
      d.cnt = '0;
    end else begin
      if (push) begin
        d.mem[q.wr] = in_data;
        d.wr        = q.wr + AW'(1);
      end
      if (pop) begin
        d.rd = q.rd + AW'(1);
      end
      d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // state register
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

endmodule : tws_fifo

/* File: verilog/tws_read_engine.sv */
// tws_read_engine: two-wire bus slave with read pointer and prefetch
// assumes scl and sda arrive from pins, asynchronous to mclk;
// the memory answers the presented address with valid and data
`timescale 1ns/1ps
module tws_read_engine (
  input  wire logic                     mclk,
  input  wire logic                     rstn,
  input  wire logic                     scl_i,
  input  wire logic                     sda_i,
  output tws_pkg::tws_pin_out_type      sda_out,
  input  wire logic [7:0]               nv_dev_addr,
  output logic [7:0]                    mem_addr,
  input  wire tws_pkg::tws_mem_rsp_type mem_rsp,
  output logic                          mem_rd_ready,
  output logic                          busy
);
  import tws_pkg::*;

  // ************************************************************
  // state and local signals
  // ************************************************************
  tws_core_type q;
  tws_core_type n;

  logic       flush_c;
  logic       pop_c;
  logic       fifo_in_ready;
  logic       fifo_out_valid;
  logic [7:0] fifo_out_data;

  // ************************************************************
  // prefetch buffer
  // ************************************************************
  // bytes ptr .. fetch-1 wait here ready to send
  tws_fifo #(
    .W (BYTE_W),
    .D (FIFO_DEPTH)
  ) u_fifo (
    .mclk      (mclk),
    .rstn      (rstn),
    .flush     (flush_c),
    .in_valid  (mem_rsp.valid & ~flush_c),
    .in_data   (mem_rsp.data),
    .in_ready  (fifo_in_ready),
    .out_valid (fifo_out_valid),
    .out_data  (fifo_out_data),
    .out_ready (pop_c)
  );

  // ************************************************************
  // outputs
  // ************************************************************
  // memory is stalled while full or while the pointer reloads
  assign mem_rd_ready = fifo_in_ready & ~flush_c;
  assign mem_addr     = q.fetch;
  // sda only ever pulled low; scl never driven
  assign sda_out.o    = 1'b0;
  assign sda_out.oe   = q.oe;
  assign busy         = (q.st != ST_IDLE);

  // ************************************************************
  // next-state logic
  // ************************************************************
  always_comb begin
    logic       scl_rise;
    logic       scl_fall;
    logic       start_c;
    logic       stop_c;
    logic       last_bit;
    logic       sel_ok;
    logic       do_load;
    logic [7:0] tx_byte;

    scl_rise = 1'b0;
    scl_fall = 1'b0;
    start_c  = 1'b0;
    stop_c   = 1'b0;
    last_bit = 1'b0;
    sel_ok   = 1'b0;
    do_load  = 1'b0;
    tx_byte  = EMPTY_BYTE;
    n        = q;
    flush_c  = 1'b0;
    pop_c    = 1'b0;

    // three-flop sync; a level counts once flops two and three agree
    n.scl_s = {q.scl_s[1:0], scl_i};
    n.sda_s = {q.sda_s[1:0], sda_i};
    if (q.scl_s[1] == q.scl_s[2]) begin
      n.scl_f = q.scl_s[2];
    end
    if (q.sda_s[1] == q.sda_s[2]) begin
      n.sda_f = q.sda_s[2];
    end

    // filter delay is a few mclk, far below either bus rate
    scl_rise = n.scl_f & ~q.scl_f;
    scl_fall = ~n.scl_f & q.scl_f;

    // conditions: sda moving while scl stays high
    start_c  = q.scl_f & n.scl_f & q.sda_f & ~n.sda_f;
    stop_c   = q.scl_f & n.scl_f & ~q.sda_f & n.sda_f;
    last_bit = (q.bitc == BYTE_BITS);

    // address match on control code and select bits
    sel_ok = (q.sh[7:4] == CTRL_CODE) &&
             ((q.sh[3:1] == FIX_SEL) ||
              (q.sh[3:1] == nv_dev_addr[3:1]));

    // protocol sequencer
    unique case (q.st)
      ST_IDLE: begin
        n.oe = 1'b0;
      end

      // receive address, pointer or data byte msb first
      ST_ADDR, ST_PTR, ST_DATA: begin
        if (scl_rise) begin
          n.sh   = {q.sh[6:0], q.sda_f};
          n.bitc = q.bitc + 4'h1;
        end
        if (scl_fall && last_bit) begin
          n.bitc = 4'h0;
          if (q.st == ST_ADDR) begin
            if (sel_ok) begin
              n.oe       = 1'b1;
              n.rw       = q.sh[0];
              n.ptr_done = 1'b0;
              n.st       = ST_ACK;
            end else begin
              // mismatch: no ack, wait for next start
              n.st = ST_IDLE;
            end
          end else if (q.st == ST_PTR) begin
            // byte address reloads pointer and prefetch
            n.ptr      = q.sh;
            n.fetch    = q.sh;
            flush_c    = 1'b1;
            n.ptr_done = 1'b1;
            n.oe       = 1'b1;
            n.st       = ST_ACK;
          end else begin
            // write data is acknowledged and discarded
            n.oe = 1'b1;
            n.st = ST_ACK;
          end
        end
      end

      // hold ack low over the whole ninth pulse
      ST_ACK: begin
        if (scl_fall) begin
          n.oe   = 1'b0;
          n.bitc = 4'h0;
          if (q.rw) begin
            do_load = 1'b1;
          end else if (q.ptr_done) begin
            n.st = ST_DATA;
          end else begin
            n.st = ST_PTR;
          end
        end
      end

      // shift out a byte, changing sda only after scl falls
      ST_TX: begin
        if (scl_rise) begin
          n.bitc = q.bitc + 4'h1;
        end
        if (scl_fall) begin
          if (last_bit) begin
            n.oe = 1'b0;
            n.st = ST_MACK;
          end else begin
            n.sh = {q.sh[6:0], 1'b0};
            n.oe = ~q.sh[6];
          end
        end
      end

      // master ack bit decides whether to continue
      ST_MACK: begin
        n.oe = 1'b0;
        if (scl_rise) begin
          n.mack = ~q.sda_f;
        end
        if (scl_fall) begin
          if (q.mack) begin
            do_load = 1'b1;
          end else begin
            // nack: sda released, master may stop
            n.st = ST_IDLE;
          end
        end
      end

      default: begin
        n.st = ST_IDLE;
        n.oe = 1'b0;
      end
    endcase

    // load next byte from the prefetch buffer
    if (do_load) begin
      if (fifo_out_valid) begin
        tx_byte = fifo_out_data;
      end
      pop_c  = fifo_out_valid;
      n.sh   = tx_byte;
      n.ptr  = q.ptr + 8'h01;
      n.oe   = ~tx_byte[7];
      n.bitc = 4'h0;
      n.st   = ST_TX;
    end

    // advance fetch address as memory bytes enter the buffer
    // same terms as mem_rd_ready, read here without looping through the port
    if (mem_rsp.valid && fifo_in_ready && !flush_c) begin
      n.fetch = q.fetch + 8'h01;
    end

    // start or repeated start restarts; stop returns to idle, pointer and prefetch kept
    if (start_c) begin
      n.st   = ST_ADDR;
      n.bitc = 4'h0;
      n.oe   = 1'b0;
      pop_c  = 1'b0;
      n.ptr  = q.ptr;
      n.sh   = q.sh;
    end else if (stop_c) begin
      n.st   = ST_IDLE;
      n.oe   = 1'b0;
      pop_c  = 1'b0;
      n.ptr  = q.ptr;
    end
  end

  // ************************************************************
  // state register
  // ************************************************************
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      q          <= '0;
      q.scl_s    <= SYNC_RST;
      q.sda_s    <= SYNC_RST;
      q.scl_f    <= 1'b1;
      q.sda_f    <= 1'b1;
      q.st       <= ST_IDLE;
      q.ptr      <= PTR_RST;
      q.fetch    <= PTR_RST;
    end else begin
      q <= n;
    end
  end

endmodule : tws_read_engine

/* File: tb/tws_chk.sv */
// tws_chk: timing checks on the read engine ports
// assumes binding to tws_read_engine, one mclk domain
`timescale 1ns/1ps
module tws_chk (
  input wire logic                     mclk,
  input wire logic                     rstn,
  input wire logic                     scl_i,
  input wire logic                     sda_i,
  input wire tws_pkg::tws_pin_out_type sda_out,
  input wire logic [7:0]               mem_addr,
  input wire tws_pkg::tws_mem_rsp_type mem_rsp,
  input wire logic                     mem_rd_ready,
  input wire logic                     busy
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  property p_pull_only;
    sda_out.o == 1'b0;
  endproperty
  a_pull_only: assert property (p_pull_only) else $error("sda driven high");
  property p_take_step;
    mem_rsp.valid && mem_rd_ready |=> mem_addr == $past(mem_addr) + 8'h01;
  endproperty
  a_take_step: assert property (p_take_step) else $error("fetch address did not step");
  property p_wrap;
    mem_rsp.valid && mem_rd_ready && mem_addr == 8'hFF |=> mem_addr == 8'h00;
  endproperty
  a_wrap: assert property (p_wrap) else $error("fetch address did not wrap");
  property p_drive_low_phase;
    $rose(sda_out.oe) |-> !scl_i;
  endproperty
  a_drive_low_phase: assert property (p_drive_low_phase) else $error("sda pulled while scl high");
  property p_hold_high;
    $rose(scl_i) && sda_out.oe |-> sda_out.oe [*4];
  endproperty
  a_hold_high: assert property (p_hold_high) else $error("sda released during scl high");
  property p_start_busy;
    scl_i && $fell(sda_i) |-> ##[1:8] busy;
  endproperty
  a_start_busy: assert property (p_start_busy) else $error("start not seen");
  property p_stop_idle;
    scl_i && $rose(sda_i) |-> ##[1:8] !busy;
  endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("stop not seen");
  property p_idle_quiet;
    !busy ##1 !busy |-> !sda_out.oe;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("sda pulled while idle");
endmodule : tws_chk
bind tws_read_engine tws_chk tws_chk_i (.mclk(mclk), .rstn(rstn), .scl_i(scl_i), .sda_i(sda_i),
  .sda_out(sda_out), .mem_addr(mem_addr), .mem_rsp(mem_rsp), .mem_rd_ready(mem_rd_ready), .busy(busy));

/* File: tb/tws_master.sv */
// tws_master: behavioural two-wire bus master
// assumes a pull-up on sda; scl stands high outside frames;
// 400 ns scl period, every step lands on a falling mclk edge
`timescale 1ns/1ps
module tws_master #(
  parameter int LOW  = 250,
  parameter int HIGH = 150
) (
  output logic      scl,
  output logic      sda_pull,
  input  wire logic sda
);
  // sda moves this long after scl falls, before the slave's filtered scl shows the fall
  localparam int SETUP = 100;
  // idle bus: both lines high
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end
  task put_bit(input logic b);
    #SETUP sda_pull = !b;
    #(LOW-SETUP) scl = 1'b1;
    #HIGH scl = 1'b0;
  endtask : put_bit
  task get_bit(output logic b);
    #SETUP sda_pull = 1'b0;
    #(LOW-SETUP) scl = 1'b1;
    #(HIGH-50) b = sda;
    #50 scl = 1'b0;
  endtask : get_bit
  task cond_start;
    sda_pull = 1'b1;
    #HIGH scl = 1'b0;
  endtask : cond_start
  task cond_restart;
    #SETUP sda_pull = 1'b0;
    #(LOW-SETUP) scl = 1'b1;
    #HIGH cond_start();
  endtask : cond_restart
  task cond_stop;
    #SETUP sda_pull = 1'b1;
    #(LOW-SETUP) scl = 1'b1;
    #HIGH sda_pull = 1'b0;
    #HIGH;
  endtask : cond_stop
  task send_byte(input logic [7:0] d, output logic ack);
    for (int i = 7; i >= 0; i--) put_bit(d[i]);
    get_bit(ack);
  endtask : send_byte
  task recv_byte(input logic mack, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) get_bit(d[i]);
    put_bit(!mack);
  endtask : recv_byte
endmodule : tws_master

/* File: tb/tws_read_engine_tb.sv */
// tws_read_engine_tb: read sequences through the master model
// assumes tws_master as partner and tws_chk bound to the engine
`timescale 1ns/1ps
module tws_read_engine_tb;
  import tws_pkg::*;
  logic            mclk, rstn, scl, m_pull, sda, stall, ack, mem_rd_ready, busy;
  logic [7:0]      nv, mem_addr, rd;
  tws_mem_rsp_type mem_rsp;
  tws_pin_out_type sda_out;
  int              failures, cmp_count;
  assign sda = !(m_pull | sda_out.oe); // pulled-up wire
  tws_master #(.LOW(250), .HIGH(150)) tws_master_i (.scl(scl), .sda_pull(m_pull), .sda(sda));
  tws_read_engine tws_read_engine_i (.mclk(mclk), .rstn(rstn), .scl_i(scl), .sda_i(sda), .sda_out(sda_out),
    .nv_dev_addr(nv), .mem_addr(mem_addr), .mem_rsp(mem_rsp), .mem_rd_ready(mem_rd_ready), .busy(busy));
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  // memory: byte is address xor 5A, valid gaps while stalling
  always @(negedge mclk) begin
    mem_rsp.valid <= !stall | !mem_rsp.valid;
    mem_rsp.data <= mem_addr ^ 8'h5A;
  end
  task chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task complete_run;
    $display("failures=%0d compares=%0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : complete_run
  task wait_idle;
    for (int n = 0; n < 40 && busy !== 1'b0; n++) @(negedge mclk);
    if (busy !== 1'b0) begin
      failures++;
      complete_run();
    end
  endtask : wait_idle
  task t_fill;
    repeat (20) @(negedge mclk);
    chk(mem_addr, 8'h08);
    chk({7'h00, mem_rd_ready}, 8'h00);
  endtask : t_fill
  task t_random;
    stall = 1'b1;
    tws_master_i.cond_start();
    tws_master_i.send_byte(8'hA0, ack);
    chk({7'h00, ack}, 8'h00);
    tws_master_i.send_byte(8'hFE, ack);
    chk({7'h00, ack}, 8'h00);
    tws_master_i.cond_restart();
    tws_master_i.send_byte(8'hA1, ack);
    chk({7'h00, ack}, 8'h00);
    tws_master_i.recv_byte(1'b1, rd);
    chk(rd, 8'hFE ^ 8'h5A);
    tws_master_i.recv_byte(1'b1, rd);
    chk(rd, 8'hFF ^ 8'h5A);
    tws_master_i.recv_byte(1'b0, rd);
    chk(rd, 8'h00 ^ 8'h5A);
    chk({7'h00, sda_out.oe}, 8'h00);
    tws_master_i.cond_stop();
    wait_idle();
    stall = 1'b0;
  endtask : t_random
  task t_read(input logic [7:0] adr, input logic [7:0] exp);
    tws_master_i.cond_start();
    tws_master_i.send_byte(adr, ack);
    chk({7'h00, ack}, 8'h00);
    tws_master_i.recv_byte(1'b0, rd);
    chk(rd, exp);
    tws_master_i.cond_stop();
    wait_idle();
  endtask : t_read
  task t_miss(input logic [7:0] adr);
    tws_master_i.cond_start();
    tws_master_i.send_byte(adr, ack);
    chk({7'h00, ack}, 8'h01);
    wait_idle();
    tws_master_i.cond_stop();
  endtask : t_miss
  initial begin
    rstn = 1'b0;
    nv = 8'h8C;
    stall = 1'b0;
    failures = 0;
    cmp_count = 0;
    repeat (16) @(negedge mclk);
    chk({6'h00, busy, sda_out.oe}, 8'h00);
    chk(mem_addr, 8'h00);
    rstn = 1'b1;
    t_fill();
    t_random();
    t_read(8'hA1, 8'h01 ^ 8'h5A);
    t_read(8'hAD, 8'h02 ^ 8'h5A);
    t_miss(8'hA7);
    t_miss(8'h21);
    t_read(8'hA1, 8'h03 ^ 8'h5A);
    complete_run();
  end
endmodule : tws_read_engine_tb
